/* rtl/msd_pkg.sv */
package msd_pkg;

  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int          NUM_PORTS   = 6;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          HOLD_MS     = 15;
  localparam int          HOLD_CYC    = (CLK_HZ / 1000) * HOLD_MS;
  localparam int          CNT_W       = 18;
  localparam logic [5:0]  PORTS_NONE  = 6'h00;
  localparam logic [5:0]  PORTS_ALL   = 6'h3f;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPEN_ALL,
    ST_FIRST,
    ST_SECOND,
    ST_GAP
  } msd_state_type;

endpackage

/* rtl/msd_hold_timer.sv */
// Hold timer: counts a fixed number of cycles after start, pulses done
module msd_hold_timer #(
  parameter int HOLD = msd_pkg::HOLD_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  output logic      done_o
);

  logic [msd_pkg::CNT_W-1:0] cnt_q;
  logic [msd_pkg::CNT_W-1:0] cnt_d;
  logic                      run_q;
  logic                      run_d;
  logic                      done_q;
  logic                      done_d;

  // Next count; restart wins over a running count
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start_i) begin
      cnt_d = msd_pkg::CNT_W'(HOLD - 1);
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule

/* rtl/msd_sequencer.sv */
// Host-side sequencer for a six-port latching matrix switch.
// Limitation: no position feedback is read, so the path record assumes
// every grounded line latched its switch within one hold; a jammed
// switch is not seen here and must be caught by the indicator logic.
// Lines are pulsed per phase rather than held as levels, so an idle
// controller never leaves a coil line grounded.
// Requests are taken only in idle; nothing is queued.
module msd_sequencer #(
  // Cycles per hold; the default is the full latch time
  parameter int HOLD = msd_pkg::HOLD_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Request side
  input  wire logic       req_valid_i,
  input  wire logic [2:0] req_port_a_i,
  input  wire logic [2:0] req_port_b_i,
  input  wire logic       req_mbb_i,
  input  wire logic       req_open_all_i,
  output logic            req_ready_o,
  output logic            req_error_o,
  output logic [5:0]      closed_ports_o,
  // Drive pins, active low: 0 = grounded
  output logic [5:0]      port_select_line_n_o,
  output logic [5:0]      port_release_line_n_o,
  output logic            open_all_line_n_o
);

  // Sequencer state
  msd_pkg::msd_state_type state_q;
  msd_pkg::msd_state_type state_d;
  // Drive line registers, active high inside, inverted at the pins
  logic [5:0]             sel_q;
  logic [5:0]             sel_d;
  logic [5:0]             rel_q;
  logic [5:0]             rel_d;
  logic                   oall_q;
  logic                   oall_d;
  // Record of latched ports and the path being built
  logic [5:0]             closed_q;
  logic [5:0]             closed_d;
  logic [5:0]             tgt_q;
  logic [5:0]             tgt_d;
  // Transition order and refusal flag of the request in hand
  logic                   mbb_q;
  logic                   mbb_d;
  logic                   err_q;
  logic                   err_d;
  // Hold timer handshake
  logic                   tmr_start;
  logic                   tmr_done;
  // Request decode
  logic [5:0]             want;
  logic                   bad_req;

  // ****************************************
  // Request decode
  // ****************************************
  // Refuse a pair that is not two distinct ports in range; one port
  // alone would leave the path half formed
  always_comb begin
    bad_req = (req_port_a_i == req_port_b_i)
            || (req_port_a_i >= 3'(msd_pkg::NUM_PORTS))
            || (req_port_b_i >= 3'(msd_pkg::NUM_PORTS));
  end

  // One comparator per port; an out-of-range code matches no bit, so it
  // can never alias onto a real port
  for (genvar p = 0; p < msd_pkg::NUM_PORTS; p++) begin : g_want
    assign want[p] = (req_port_a_i == 3'(p)) || (req_port_b_i == 3'(p));
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Every phase drives only one group of lines; the rest are released,
  // so select and release of one port never overlap
  always_comb begin
    state_d   = state_q;
    sel_d     = msd_pkg::PORTS_NONE;
    rel_d     = msd_pkg::PORTS_NONE;
    oall_d    = 1'b0;
    closed_d  = closed_q;
    tgt_d     = tgt_q;
    mbb_d     = mbb_q;
    err_d     = 1'b0;
    tmr_start = 1'b0;
    case (state_q)
      // Only idle takes requests; one that arrives while busy is never seen
      msd_pkg::ST_IDLE: begin
        if (req_valid_i && req_open_all_i) begin
          oall_d    = 1'b1;
          tmr_start = 1'b1;
          state_d   = msd_pkg::ST_OPEN_ALL;
        end else if (req_valid_i && bad_req) begin
          err_d = 1'b1; // Rejected, pins untouched
        end else if (req_valid_i) begin
          tgt_d     = want;
          mbb_d     = req_mbb_i;
          tmr_start = 1'b1;
          state_d   = msd_pkg::ST_FIRST;
          if (req_mbb_i) begin
            // Make first: both ports of the new path are driven
            sel_d = want;
          end else begin
            // Break first: only closed ports outside the new path
            rel_d = closed_q & ~want;
          end
        end
      end
      // Port lines stay released throughout, so no coil fights open-all
      msd_pkg::ST_OPEN_ALL: begin
        oall_d = 1'b1; // Held for the full latch time
        if (tmr_done) begin
          // Every port is now open, whatever the record said
          oall_d   = 1'b0;
          closed_d = msd_pkg::PORTS_NONE;
          state_d  = msd_pkg::ST_IDLE;
        end
      end
      // A phase with an empty set still waits out the hold; simpler than
      // skipping it, and it costs only one hold per path
      msd_pkg::ST_FIRST: begin
        sel_d = mbb_q ? tgt_q : msd_pkg::PORTS_NONE;
        rel_d = mbb_q ? msd_pkg::PORTS_NONE : (closed_q & ~tgt_q);
        if (tmr_done) begin
          // Switch lines from first group to second with one idle
          // cycle so no port sees both lines at the same edge
          sel_d   = msd_pkg::PORTS_NONE;
          rel_d   = msd_pkg::PORTS_NONE;
          state_d = msd_pkg::ST_GAP;
        end
      end
      // One released cycle between phases, so the two groups are never
      // live together; the timer is restarted for the second group here
      msd_pkg::ST_GAP: begin
        tmr_start = 1'b1;
        state_d   = msd_pkg::ST_SECOND;
        if (mbb_q) begin
          rel_d = closed_q & ~tgt_q;
        end else begin
          sel_d = tgt_q;
        end
      end
      // The record changes only once both phases have run their hold
      msd_pkg::ST_SECOND: begin
        sel_d = mbb_q ? msd_pkg::PORTS_NONE : tgt_q;
        rel_d = mbb_q ? (closed_q & ~tgt_q) : msd_pkg::PORTS_NONE;
        if (tmr_done) begin
          sel_d    = msd_pkg::PORTS_NONE;
          rel_d    = msd_pkg::PORTS_NONE;
          closed_d = tgt_q;
          state_d  = msd_pkg::ST_IDLE;
        end
      end
      // Unused codes fall back to idle with every line released
      default: begin
        state_d = msd_pkg::ST_IDLE;
      end
    endcase
    // Final mask on the pin pattern: whatever the state, a port never
    // sees both of its lines, and no port line rides with open-all
    rel_d = rel_d & ~sel_d;
    if (oall_d) begin
      sel_d = msd_pkg::PORTS_NONE;
      rel_d = msd_pkg::PORTS_NONE;
    end
  end

  // Registers; reset releases every line, and the switch simply keeps
  // the path it last latched
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q  <= msd_pkg::ST_IDLE;
      sel_q    <= msd_pkg::PORTS_NONE;
      rel_q    <= msd_pkg::PORTS_NONE;
      oall_q   <= 1'b0;
      closed_q <= msd_pkg::PORTS_NONE;
      tgt_q    <= msd_pkg::PORTS_NONE;
      mbb_q    <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      sel_q    <= sel_d;
      rel_q    <= rel_d;
      oall_q   <= oall_d;
      closed_q <= closed_d;
      tgt_q    <= tgt_d;
      mbb_q    <= mbb_d;
      err_q    <= err_d;
    end
  end

  // ****************************************
  // Hold timer, 15 ms per phase
  // ****************************************
  // Shared by every phase; a start in the gap cycle reloads it, so the
  // second phase gets a full hold of its own
  msd_hold_timer #(
    .HOLD (HOLD)
  ) u_hold (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (tmr_start),
    .done_o    (tmr_done)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Grounded line = logic 0 at the pin
  // Lines come straight from flops, so no glitch reaches a coil driver
  assign port_select_line_n_o  = ~sel_q;
  assign port_release_line_n_o = ~rel_q;
  assign open_all_line_n_o     = ~oall_q;

  // Status toward the requester; ready is decoded from the state register
  assign req_ready_o           = (state_q == msd_pkg::ST_IDLE);
  assign req_error_o           = err_q;
  assign closed_ports_o        = closed_q;

endmodule

/* bench/msd_seq_chk.sv */
// **********************************
// Sequencer pin checker
// **********************************
module msd_seq_chk #(
  parameter int HOLD = msd_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  // Request side
  input wire logic       req_valid_i,
  input wire logic [2:0] req_port_a_i,
  input wire logic [2:0] req_port_b_i,
  input wire logic       req_open_all_i,
  input wire logic       req_ready_o,
  input wire logic       req_error_o,
  input wire logic [5:0] closed_ports_o,
  // Drive pins
  input wire logic [5:0] port_select_line_n_o,
  input wire logic [5:0] port_release_line_n_o,
  input wire logic       open_all_line_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int  sel_run_q;
  int  rel_run_q;
  int  all_run_q;
  wire sel_idle = &port_select_line_n_o;
  wire rel_idle = &port_release_line_n_o;
  // Low-run lengths; a counter, since a repeat cannot reach a 15 ms hold
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_run_q <= 0;
      rel_run_q <= 0;
      all_run_q <= 0;
    end else begin
      sel_run_q <= sel_idle ? 0 : sel_run_q + 1;
      rel_run_q <= rel_idle ? 0 : rel_run_q + 1;
      all_run_q <= open_all_line_n_o ? 0 : all_run_q + 1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_bad_take;
    req_valid_i && req_ready_o && !req_open_all_i && (req_port_a_i == req_port_b_i
      || req_port_a_i > 3'h5 || req_port_b_i > 3'h5);
  endsequence
  AST_BAD_REQ: assert property (s_bad_take |=> req_error_o && sel_idle && rel_idle)
    else $error("bad request not refused");
  AST_TWO_PORTS: assert property (!sel_idle |-> $countones(~port_select_line_n_o) == 2)
    else $error("close set is not two ports");
  AST_NO_FIGHT: assert property ((~port_select_line_n_o & ~port_release_line_n_o) == 6'h00)
    else $error("close and open of one port together");
  AST_ALL_NO_SEL: assert property (!open_all_line_n_o |-> sel_idle)
    else $error("close line with open-all");
  AST_ALL_NO_REL: assert property (!open_all_line_n_o |-> rel_idle)
    else $error("open line with open-all");
  AST_SEL_HOLD: assert property ($rose(sel_idle) |-> sel_run_q >= HOLD)
    else $error("close pulse too short");
  AST_REL_HOLD: assert property ($rose(rel_idle) |-> rel_run_q >= HOLD)
    else $error("open pulse too short");
  AST_ALL_HOLD: assert property ($rose(open_all_line_n_o) |-> all_run_q >= HOLD)
    else $error("open-all pulse too short");
  AST_PHASE_GAP: assert property ($fell(sel_idle) |-> $past(rel_idle))
    else $error("close phase overlaps open phase");
  AST_IDLE_FREE: assert property (req_ready_o |-> sel_idle && rel_idle && open_all_line_n_o)
    else $error("line grounded while idle");
  AST_RECORD: assert property (req_ready_o |-> $countones(closed_ports_o) inside {0, 2})
    else $error("closed record not a path");
endmodule

bind msd_sequencer msd_seq_chk #(.HOLD(HOLD)) u_chk (.*);

/* bench/msd_switch_model.sv */
// **********************************
// Latching six-port switch model
// **********************************
module msd_switch_model #(
  parameter int LATCH = 100
) (
  input  wire logic       clk_sys_i,
  input  wire logic [5:0] sel_n_i,
  input  wire logic [5:0] rel_n_i,
  input  wire logic       all_n_i,
  output logic [5:0]      closed_o,
  output logic [5:0]      coil_on_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] closed_q = 6'h00;
  int         cnt_q [6] = '{default: 0};
  assign closed_o = closed_q;
  // Grounded lines energise only switches not already in place
  assign coil_on_o = (~sel_n_i & ~closed_q) | ((~rel_n_i | {6{~all_n_i}}) & closed_q);
  // Latching flips the switch, which drops its own coil current
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 6; i++) begin
      if (!coil_on_o[i]) begin
        cnt_q[i] <= 0;
      end else if (cnt_q[i] == LATCH - 1) begin
        cnt_q[i] <= 0;
        closed_q[i] <= ~closed_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1;
      end
    end
  end
endmodule

/* bench/msd_sequencer_bench.sv */
module msd_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i, rst_i, req_valid_i, req_mbb_i, req_open_all_i, err_seen;
  logic [2:0] req_port_a_i, req_port_b_i;
  logic       req_ready_o, req_error_o, open_all_line_n_o;
  logic [5:0] closed_ports_o, port_select_line_n_o, port_release_line_n_o, dev_closed, coil_on;
  int         error_cnt = 0;
  int         checks_done = 0;
  // Short hold keeps the run brief; still well above the model's latch
  // time, and the pulse-width checks scale with it
  localparam int HOLD = 200;
  msd_sequencer #(.HOLD(HOLD)) dut (.*);
  msd_switch_model #(.LATCH(100)) u_dev (.clk_sys_i(clk_sys_i), .sel_n_i(port_select_line_n_o),
    .rel_n_i(port_release_line_n_o), .all_n_i(open_all_line_n_o), .closed_o(dev_closed),
    .coil_on_o(coil_on));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // **********************************
  // Shared tasks
  // **********************************
  task automatic chk(input string name, input logic [5:0] seen, input logic [5:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for a pin pattern and ready level
  task automatic wait_pins(input logic [5:0] sel, input logic [5:0] rel, input logic rdy);
    int n;
    n = 0;
    while (!(port_select_line_n_o === sel && port_release_line_n_o === rel &&
             req_ready_o === rdy)) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 2 * HOLD + 9) begin
        error_cnt++;
        results();
      end
    end
  endtask
  // Request held one cycle; returns just after the taking edge
  task automatic req(input logic [2:0] a, input logic [2:0] b, input logic mbb, input logic oa);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_port_a_i <= a;
    req_port_b_i <= b;
    req_mbb_i <= mbb;
    req_open_all_i <= oa;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    #1;
    err_seen = req_error_o;
  endtask
  task automatic path(input logic [2:0] a, input logic [2:0] b, input logic mbb,
                      input logic [5:0] s1, input logic [5:0] r1, input logic [5:0] s2,
                      input logic [5:0] r2, input logic [5:0] done);
    req(a, b, mbb, 1'b0);
    @(posedge clk_sys_i);
    #1;
    chk("first close", port_select_line_n_o, s1);
    chk("first open", port_release_line_n_o, r1);
    wait_pins(s2, r2, 1'b0);
    wait_pins(6'h3f, 6'h3f, 1'b1);
    chk("record", closed_ports_o, done);
    chk("device", dev_closed, done);
    chk("coils", coil_on, 6'h00);
  endtask
  // **********************************
  // Scenarios
  // **********************************
  task automatic t_reset;
    chk("close idle", port_select_line_n_o, 6'h3f);
    chk("open idle", port_release_line_n_o, 6'h3f);
    chk("record", closed_ports_o, 6'h00);
  endtask
  task automatic t_open_all;
    req(3'h2, 3'h2, 1'b0, 1'b1);
    @(posedge clk_sys_i);
    #1;
    chk("open-all", {5'h00, open_all_line_n_o}, 6'h00);
    chk("close lines", port_select_line_n_o, 6'h3f);
    wait_pins(6'h3f, 6'h3f, 1'b1);
    chk("device", dev_closed, 6'h00);
  endtask
  // Duplicate and out-of-range ports are refused with no pin change
  task automatic t_error;
    req(3'h2, 3'h2, 1'b0, 1'b0);
    chk("error", {5'h00, err_seen}, 6'h01);
    req(3'h6, 3'h0, 1'b1, 1'b0);
    chk("error", {5'h00, err_seen}, 6'h01);
    chk("close lines", port_select_line_n_o, 6'h3f);
  endtask
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_port_a_i = 3'h0;
    req_port_b_i = 3'h0;
    req_mbb_i = 1'b0;
    req_open_all_i = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_open_all();
    path(3'h0, 3'h1, 1'b0, 6'h3f, 6'h3f, ~6'h03, 6'h3f, 6'h03);
    path(3'h1, 3'h2, 1'b0, 6'h3f, ~6'h01, ~6'h06, 6'h3f, 6'h06);
    path(3'h4, 3'h3, 1'b1, ~6'h18, 6'h3f, 6'h3f, ~6'h06, 6'h18);
    t_error();
    t_open_all();
    results();
  end
endmodule
